// >>> shared/cfg_life_pkg.sv
// Shared constants and types for the serial configuration lifephase sequencer
package cfg_life_pkg;

	// Lifephases
	typedef enum logic [2:0] {
		PH_POWER_ON,
		PH_MANUAL_RESET,
		PH_MODE_SAMPLING,
		PH_IDLE,
		PH_DOWNLOAD,
		PH_RUN
	} phase_t;

	// Timing, in nanoseconds, and the derived counts at 250 MHz
	localparam int CLK_PERIOD_NS     = 4;
	localparam int CLEAR_CYCLE_NS    = 2000000;
	localparam int ERR_LOW_NS        = 1000;
	localparam int CLEAR_CYCLES      = CLEAR_CYCLE_NS / CLK_PERIOD_NS;
	localparam int ERR_LOW_CYCLES    = (ERR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Handshake low periods seen before the device takes over the line
	localparam int START_LOW_PERIODS = 3;
	// Serial clock periods between postamble match and run
	localparam int RUN_DELAY_PERIODS = 4;

	// Stream framing
	localparam logic [7:0] PREAMBLE  = 8'hb7;
	localparam logic [7:0] POSTAMBLE = 8'he7;
	localparam logic [2:0] MODE_AUTO = 3'h0;

	// Pin group: each open-drain pin as output level and active-low enable
	typedef struct packed {
		logic handshake_o;
		logic handshake_oe_n;
		logic error_flag_o;
		logic error_flag_oe_n;
	} cfg_pins_t;

	// Stream events from the frame checker
	typedef struct packed {
		logic preamble_bad;
		logic postamble_bad;
		logic postamble_ok;
		logic checksum_bad;
	} stream_evt_t;

endpackage : cfg_life_pkg

// >>> rtl/cfg_lifephase.sv
// Lifephase sequencer for slave serial configuration download
`timescale 1ns/100ps

// Overview of operation
// - In run, a low handshake line from the master starts download at once.
// - In run the handshake is released high; config pins stay user I/O.
// - Download samples serial data on every rising serial clock edge until a framing mismatch.
// - After three serial periods of handshake low, device drives it low itself.
// - During download the error flag is pulled up and signals errors.
// - Reset, sampling and download drive low-config low and high-config high.
// - A few serial clocks after postamble, enter run and release all pins.
// - Outside power-on, manual reset forces the manual reset phase at once.
// - Power-on reset ignores the manual reset input entirely.
// - Power-on keeps error flag pulled up until clear end, then low 1 us.
// - Each reset phase ends on error flag rising edge; mode sampling follows.
// - Mode sampling reads three mode pins; mode 0 starts automatic download.
// - During mode sampling serial data shows the memory's first bit.
// - Reset phases and mode sampling drive the handshake line low.
// - Idle starts once handshake and error flag are released; handshake high.
// - Manual reset runs a 2 ms clear cycle, held even for short pulses.
// - In manual reset the error flag is low until the reset pin releases.
// - Mode pins are ignored after mode sampling completes.
// - Framing mismatch pulses error flag low one serial period, then aborts.
// - Checksum mismatch drives error flag low but download still reaches run.
module cfg_lifephase
	import cfg_life_pkg::*;
#(
	parameter int CLEAR_COUNT = CLEAR_CYCLES
) (
	// Clock and power-on reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// Configuration pins
	input  wire logic                   config_serial_clock,
	input  wire logic                   config_serial_data_in,
	input  wire logic                   config_start_handshake_in,
	input  wire logic                   error_flag_pin_in,
	input  wire logic                   manual_reset_n,
	input  wire logic                   mode_pin_bit0,
	input  wire logic                   mode_pin_bit1,
	input  wire logic                   mode_pin_bit2,
	output cfg_life_pkg::cfg_pins_t     pins,
	output logic                        low_during_config_out,
	output logic                        high_during_config_out,
	// Stream towards the frame decoder
	input  wire cfg_life_pkg::stream_evt_t evt,
	output logic                        bit_valid,
	output logic                        bit_data,
	output logic                        user_io_enable,
	output cfg_life_pkg::phase_t        phase
);
	import cfg_life_pkg::*;

	localparam int CNT_W = $clog2(CLEAR_COUNT + 1);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers, two flops each; first stage read only by second
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic       sclk_d_r;
	always_ff @(posedge sys_clk) begin
		sync1_r <= {config_serial_clock, config_serial_data_in, config_start_handshake_in,
			error_flag_pin_in, manual_reset_n};
		sync2_r <= sync1_r;
		sclk_d_r <= sync2_r[4];
	end
	logic sclk_s, data_s, hs_s, err_s, mrst_s;
	logic sclk_rise;
	logic [2:0] mode_s1_r, mode_s2_r;
	always_ff @(posedge sys_clk) begin
		mode_s1_r <= {mode_pin_bit2, mode_pin_bit1, mode_pin_bit0};
		mode_s2_r <= mode_s1_r;
	end
	assign sclk_s    = sync2_r[4];
	assign data_s    = sync2_r[3];
	assign hs_s      = sync2_r[2];
	assign err_s     = sync2_r[1];
	assign mrst_s    = ~sync2_r[0];
	assign sclk_rise = sclk_s & ~sclk_d_r;

	////////////////////////////////////////////////////////////////////////////
	// Error flag pin rising edge marks reset end
	logic err_d_r;
	always_ff @(posedge sys_clk) begin
		err_d_r <= err_s;
	end

	////////////////////////////////////////////////////////////////////////////
	// Clear cycle and 1 us low pulse timers
	logic [CNT_W-1:0] clear_cnt_r;
	logic             clear_end;
	logic [15:0]      errlow_cnt_r;
	logic             errlow_busy_r;
	logic             errlow_done_r;
	phase_t           phase_r, phase_nxt;

	assign clear_end = (clear_cnt_r == CNT_W'(CLEAR_COUNT));

	always_ff @(posedge sys_clk) begin
		if (rst)
			clear_cnt_r <= '0;
		else if (phase_r == PH_POWER_ON || phase_r == PH_MANUAL_RESET) begin
			if (phase_r != PH_POWER_ON && mrst_s && phase_nxt == PH_MANUAL_RESET
				&& phase_r != PH_MANUAL_RESET)
				clear_cnt_r <= '0;
			else if (!clear_end)
				clear_cnt_r <= clear_cnt_r + CNT_W'(1);
		end else
			clear_cnt_r <= '0;
	end

	// Single pulse per power-on; a retrigger would mask the rising edge forever
	always_ff @(posedge sys_clk) begin
		if (rst || phase_r != PH_POWER_ON) begin
			errlow_cnt_r  <= '0;
			errlow_busy_r <= 1'b0;
			errlow_done_r <= 1'b0;
		end else if (clear_end && !errlow_busy_r && !errlow_done_r) begin
			errlow_busy_r <= 1'b1;
			errlow_cnt_r  <= 16'(ERR_LOW_CYCLES);
		end else if (errlow_busy_r) begin
			errlow_cnt_r  <= errlow_cnt_r - 16'h0001;
			errlow_busy_r <= (errlow_cnt_r != 16'h0001);
			errlow_done_r <= (errlow_cnt_r == 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Download bookkeeping, counted in serial clock edges
	logic [1:0] hs_low_cnt_r;
	logic       hs_drive_r;
	logic [2:0] run_cnt_r;
	logic       post_seen_r;
	logic       abort_r;
	logic       abort_pulse_r;
	logic       chk_bad_r;

	always_ff @(posedge sys_clk) begin
		if (rst || phase_r != PH_DOWNLOAD) begin
			hs_low_cnt_r <= '0;
			hs_drive_r   <= 1'b0;
		end else if (sclk_rise && !hs_drive_r) begin
			if (!hs_s && hs_low_cnt_r == 2'(START_LOW_PERIODS - 1))
				hs_drive_r <= 1'b1;
			hs_low_cnt_r <= hs_s ? 2'h0 : hs_low_cnt_r + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || phase_r != PH_DOWNLOAD) begin
			post_seen_r   <= 1'b0;
			run_cnt_r     <= '0;
			abort_r       <= 1'b0;
			abort_pulse_r <= 1'b0;
			chk_bad_r     <= 1'b0;
		end else begin
			if (evt.checksum_bad)
				chk_bad_r <= 1'b1;
			if ((evt.preamble_bad || evt.postamble_bad) && !abort_pulse_r)
				abort_pulse_r <= 1'b1;
			else if (abort_pulse_r && sclk_rise)
				abort_r <= 1'b1;
			if (evt.postamble_ok)
				post_seen_r <= 1'b1;
			if (post_seen_r && sclk_rise && run_cnt_r != 3'(RUN_DELAY_PERIODS))
				run_cnt_r <= run_cnt_r + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lifephase state machine
	logic err_rose_r;
	logic hs_armed_r;

	// Short manual pulse: flag may rise long before clear end, so remember it
	always_ff @(posedge sys_clk) begin
		if (rst || phase_r != PH_MANUAL_RESET || mrst_s)
			err_rose_r <= 1'b0;
		else if (err_s && !err_d_r)
			err_rose_r <= 1'b1;
	end

	// Our own low drive lingers in the synchroniser; wait for a high first
	always_ff @(posedge sys_clk) begin
		if (rst || (phase_r != PH_IDLE && phase_r != PH_RUN))
			hs_armed_r <= 1'b0;
		else if (hs_s)
			hs_armed_r <= 1'b1;
	end

	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_POWER_ON: begin
				if (err_s && !err_d_r && errlow_done_r)
					phase_nxt = PH_MODE_SAMPLING;
			end
			PH_MANUAL_RESET: begin
				if (clear_end && !mrst_s && (err_rose_r || (err_s && !err_d_r)))
					phase_nxt = PH_MODE_SAMPLING;
			end
			PH_MODE_SAMPLING: begin
				phase_nxt = (mode_s2_r == MODE_AUTO) ? PH_DOWNLOAD : PH_IDLE;
			end
			PH_IDLE: begin
				if (!hs_s && hs_armed_r)
					phase_nxt = PH_DOWNLOAD;
			end
			PH_DOWNLOAD: begin
				if (abort_r)
					phase_nxt = PH_IDLE;
				else if (run_cnt_r == 3'(RUN_DELAY_PERIODS))
					phase_nxt = PH_RUN;
			end
			PH_RUN: begin
				if (!hs_s && hs_armed_r)
					phase_nxt = PH_DOWNLOAD;
			end
			default: phase_nxt = PH_POWER_ON;
		endcase
		if (phase_r != PH_POWER_ON && mrst_s)
			phase_nxt = PH_MANUAL_RESET;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			phase_r <= PH_POWER_ON;
		else
			phase_r <= phase_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered
	logic in_cfg;
	assign in_cfg = (phase_nxt == PH_POWER_ON) || (phase_nxt == PH_MANUAL_RESET)
		|| (phase_nxt == PH_MODE_SAMPLING) || (phase_nxt == PH_DOWNLOAD);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pins                   <= '{1'b0, 1'b0, 1'b0, 1'b1};
			low_during_config_out  <= 1'b0;
			high_during_config_out <= 1'b1;
			user_io_enable         <= 1'b0;
			phase                  <= PH_POWER_ON;
		end else begin
			phase                  <= phase_nxt;
			low_during_config_out  <= ~in_cfg;
			high_during_config_out <= in_cfg;
			user_io_enable         <= (phase_nxt == PH_RUN) || (phase_nxt == PH_IDLE);
			pins.handshake_o       <= 1'b0;
			// Handshake low in resets and sampling, or once taken over
			pins.handshake_oe_n    <= !((phase_nxt == PH_POWER_ON)
				|| (phase_nxt == PH_MANUAL_RESET) || (phase_nxt == PH_MODE_SAMPLING)
				|| (phase_nxt == PH_DOWNLOAD && hs_drive_r && !abort_r));
			pins.error_flag_o      <= 1'b0;
			// Released means pulled up by the pad; low only when enabled
			pins.error_flag_oe_n   <= !((phase_nxt == PH_POWER_ON && errlow_busy_r)
				|| (phase_nxt == PH_MANUAL_RESET && mrst_s)
				|| (phase_nxt == PH_DOWNLOAD && (chk_bad_r || (abort_pulse_r && !abort_r))));
		end
	end

	// Serial bit stream to the frame decoder
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bit_valid <= 1'b0;
			bit_data  <= 1'b0;
		end else begin
			bit_valid <= (phase_r == PH_DOWNLOAD) && sclk_rise && !abort_pulse_r;
			bit_data  <= data_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	phase_t phase_prev_r;
	always_ff @(posedge sys_clk) phase_prev_r <= phase_r;

	manual_force_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r != PH_POWER_ON && mrst_s) |=> phase_r == PH_MANUAL_RESET)
		else $error("manual reset not taken");
	power_on_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_POWER_ON && !clear_end) |=> phase_r == PH_POWER_ON)
		else $error("power-on left early");
	run_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_RUN && hs_armed_r && !hs_s && !mrst_s) |=> phase_r == PH_DOWNLOAD)
		else $error("run not left on handshake low");
	config_levels_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_DOWNLOAD && $past(phase_r) == PH_DOWNLOAD)
		|-> (!low_during_config_out && high_during_config_out))
		else $error("config level pins wrong");
	sampling_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_MODE_SAMPLING) |-> !pins.handshake_oe_n)
		else $error("handshake not driven low");
	mode_route_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_MODE_SAMPLING && mode_s2_r != MODE_AUTO && !mrst_s)
		|=> phase_r == PH_IDLE)
		else $error("non-auto mode did not idle");
	run_release_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_RUN && $past(phase_r) == PH_RUN)
		|-> (pins.handshake_oe_n && pins.error_flag_oe_n && user_io_enable))
		else $error("run did not release pins");
	takeover_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(hs_drive_r) |-> hs_low_cnt_r == 2'(START_LOW_PERIODS))
		else $error("takeover before three periods");
	manual_err_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_MANUAL_RESET && mrst_s) ##1 (phase_r == PH_MANUAL_RESET)
		|-> !pins.error_flag_oe_n)
		else $error("error flag not low in manual reset");
	manual_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase_r == PH_MANUAL_RESET && !clear_end) |=> phase_r == PH_MANUAL_RESET)
		else $error("manual reset left before clear end");

	cover_auto_run_c:  cover property (@(posedge sys_clk) phase_prev_r == PH_DOWNLOAD
		&& phase_r == PH_RUN);
	cover_abort_c:     cover property (@(posedge sys_clk) abort_r);
	cover_manual_c:    cover property (@(posedge sys_clk) phase_r == PH_MANUAL_RESET);
	cover_rerun_c:     cover property (@(posedge sys_clk) phase_prev_r == PH_RUN
		&& phase_r == PH_DOWNLOAD);

endmodule : cfg_lifephase

// >>> tb/cfg_partner.sv
// Serial master and configuration memory model
`timescale 1ns/100ps
module cfg_partner #(
	parameter int NB = 24
) (
	// Bench control
	input  wire logic          go,
	input  wire logic [NB-1:0] stream,
	// Device side
	input  wire logic          dev_hs_low,
	output logic               sclk,
	output logic               sdata,
	output logic               master_hs_low,
	output int                 nrise,
	output logic               busy,
	output logic               chip_sel_n
);
	// Clock and data idle at their pull-up level between frames
	initial begin
		sclk = 1'b1;
		sdata = 1'b1;
		master_hs_low = 1'b0;
		nrise = 0;
		busy = 1'b0;
		chip_sel_n = 1'b1;
		forever begin
			@(posedge go);
			busy = 1'b1;
			chip_sel_n = 1'b0;
			nrise = 0;
			master_hs_low = 1'b1;
			sdata = stream[NB-1];
			for (int i = 1; i <= NB; i++) begin
				#62.5 sclk = 1'b0;
				#62.5 sclk = 1'b1;
				nrise = i;
				if (dev_hs_low)
					master_hs_low = 1'b0;
				// Clock-to-output delay keeps the old bit at the edge
				#20 sdata = (i < NB) ? stream[NB-1-i] : 1'b1;
			end
			master_hs_low = 1'b0;
			chip_sel_n = 1'b1;
			busy = 1'b0;
		end
	end
endmodule : cfg_partner

// >>> tb/cfg_lifephase_tb_top.sv
// Self-checking bench for the configuration lifephase sequencer
`timescale 1ns/100ps
module cfg_lifephase_tb_top;
	import cfg_life_pkg::*;
	localparam int CLR = 50;
	localparam int NB = 24;
	logic sys_clk, rst, manual_reset_n, go, low_cfg, high_cfg, bit_valid, bit_data, user_io;
	logic sclk, sdata, master_hs_low, busy, cs_n;
	logic [2:0] mode;
	logic [NB-1:0] stream;
	logic [15:0] cap;
	stream_evt_t evt;
	cfg_pins_t pins;
	phase_t phase;
	int nrise, n_errors, comparisons, nbits, base, take_at, err_low;
	wire logic hs_wire = ~(master_hs_low | ~pins.handshake_oe_n);
	wire logic err_wire = pins.error_flag_oe_n;

	cfg_lifephase #(.CLEAR_COUNT(CLR)) dut (.sys_clk(sys_clk), .rst(rst),
		.config_serial_clock(sclk), .config_serial_data_in(sdata),
		.config_start_handshake_in(hs_wire), .error_flag_pin_in(err_wire),
		.manual_reset_n(manual_reset_n), .mode_pin_bit0(mode[0]), .mode_pin_bit1(mode[1]),
		.mode_pin_bit2(mode[2]), .pins(pins), .low_during_config_out(low_cfg),
		.high_during_config_out(high_cfg), .evt(evt), .bit_valid(bit_valid),
		.bit_data(bit_data), .user_io_enable(user_io), .phase(phase));
	cfg_partner #(.NB(NB)) mem (.go(go), .stream(stream), .dev_hs_low(~pins.handshake_oe_n),
		.sclk(sclk), .sdata(sdata), .master_hs_low(master_hs_low), .nrise(nrise), .busy(busy),
		.chip_sel_n(cs_n));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (bit_valid === 1'b1) begin
			nbits <= nbits + 1;
			if (nbits - base < 16)
				cap[15-(nbits-base)] <= bit_data;
		end
		if (pins.handshake_oe_n === 1'b0 && phase === PH_DOWNLOAD && take_at < 0)
			take_at <= nrise;
		if (err_wire === 1'b0 && phase === PH_DOWNLOAD)
			err_low <= err_low + 1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_phase(input phase_t p, input int lim);
		for (int k = 0; k < lim && phase !== p; k++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask : wait_phase

	// One frame from the master; two decoder events at given bit counts
	task automatic run_frame(input stream_evt_t e1, input int a1, input stream_evt_t e2,
		input int a2);
		logic f1, f2;
		f1 = 1'b0;
		f2 = 1'b0;
		base = nbits;
		take_at = -1;
		err_low = 0;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		wait_phase(PH_DOWNLOAD, 10);
		check("download entry", phase, PH_DOWNLOAD);
		check("chip select", cs_n, 1'b0);
		for (int k = 0; k < 2000 && (k < 4 || busy === 1'b1); k++) begin
			@(posedge sys_clk);
			if (!f1 && nbits - base == a1) begin
				evt <= e1;
				f1 = 1'b1;
			end else if (!f2 && nbits - base == a2) begin
				evt <= e2;
				f2 = 1'b1;
			end else begin
				evt <= '0;
			end
		end
		#1;
	endtask : run_frame

	task automatic t_power_on;
		int k;
		int n;
		k = 0;
		n = 0;
		check("hs driven", pins.handshake_oe_n, 1'b0);
		check("ldc", low_cfg, 1'b0);
		check("hdc", high_cfg, 1'b1);
		check("pin levels", {pins.handshake_o, pins.error_flag_o}, 2'h0);
		@(posedge sys_clk);
		manual_reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		manual_reset_n <= 1'b1;
		#1;
		check("por phase", phase, PH_POWER_ON);
		for (k = 11; k < 2000 && err_wire !== 1'b0; k++)
			@(posedge sys_clk);
		check("clear len", k >= CLR, 1'b1);
		for (n = 0; n < 2000 && err_wire === 1'b0; n++)
			@(posedge sys_clk);
		check("flag low", n >= ERR_LOW_CYCLES && n <= ERR_LOW_CYCLES + 2, 1'b1);
		#1;
		wait_phase(PH_MODE_SAMPLING, 10);
		check("to sampling", phase, PH_MODE_SAMPLING);
		wait_phase(PH_IDLE, 20);
		check("to idle", phase, PH_IDLE);
		check("idle pins", {pins.handshake_oe_n, pins.error_flag_oe_n, hs_wire}, 3'h7);
		check("idle io", {user_io, low_cfg, high_cfg}, 3'h6);
		@(posedge sys_clk);
		mode <= 3'h0;
		repeat (20) @(posedge sys_clk);
		#1;
		check("mode ignored", phase, PH_IDLE);
	endtask : t_power_on

	task automatic t_download;
		run_frame(4'h1, 8, 4'h2, 16);
		check("takeover", take_at >= 3 && take_at <= 4, 1'b1);
		check("bits", cap, {PREAMBLE, POSTAMBLE});
		check("sum flag", err_low > 0, 1'b1);
		check("run", phase, PH_RUN);
		check("run pins", {pins.handshake_oe_n, pins.error_flag_oe_n, hs_wire}, 3'h7);
		check("run io", {user_io, low_cfg, high_cfg}, 3'h6);
	endtask : t_download

	task automatic t_abort;
		run_frame(4'h8, 8, 4'h0, 99);
		check("abort pulse", err_low >= 25 && err_low <= 40, 1'b1);
		check("abort idle", phase, PH_IDLE);
		check("abort hs", hs_wire, 1'b1);
	endtask : t_abort

	task automatic t_manual;
		@(posedge sys_clk);
		manual_reset_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		check("manual", phase, PH_MANUAL_RESET);
		check("manual hs", pins.handshake_oe_n, 1'b0);
		check("manual flag", err_wire, 1'b0);
		@(posedge sys_clk);
		manual_reset_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		check("short pulse", phase, PH_MANUAL_RESET);
		wait_phase(PH_DOWNLOAD, 600);
		check("auto load", phase, PH_DOWNLOAD);
		run_frame(4'h0, 99, 4'h2, 16);
		check("auto run", phase, PH_RUN);
	endtask : t_manual

	task automatic test_done;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		manual_reset_n = 1'b1;
		go = 1'b0;
		mode = 3'h1;
		evt = '0;
		stream = {PREAMBLE, POSTAMBLE, 8'h5a};
		cap = '0;
		{n_errors, comparisons, nbits, base, err_low} = '0;
		take_at = -1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		t_power_on();
		t_download();
		stream = {8'h35, POSTAMBLE, 8'h5a};
		t_abort();
		stream = {PREAMBLE, POSTAMBLE, 8'h5a};
		t_manual();
		test_done();
	end
endmodule : cfg_lifephase_tb_top
